/* File: src/arb_result_bank.v */
// read-only converter result register bank on the device register port
`timescale 1ns/10ps
`default_nettype none
`include "arb_map.vh"
module arb_result_bank #(
  parameter RES_W = 16
) (
  // clock and reset
  input  wire                    mclk_in,
  input  wire                    rst_in,
  // conversion results from the converter, same clock domain
  input  wire                    conv_done_in,
  input  wire [RES_W-1:0]        input_current_result_in,
  input  wire [RES_W-1:0]        charge_current_result_in,
  input  wire [RES_W-1:0]        input_voltage_result_in,
  // register port from the serial register interface
  input  wire [`ARB_ADDR_W-1:0]  reg_addr_in,
  input  wire                    reg_rd_in,
  input  wire                    reg_wr_in,
  input  wire [7:0]              reg_wdata_in,
  output reg  [7:0]              reg_rdata_out,
  output reg                     reg_hit_out
);
  // number of result words held in this bank
  localparam NUM_RES = `ARB_NUM_RES;

  // held result words, one per converter channel
  wire [RES_W-1:0]         in_cur_hold;
  wire [RES_W-1:0]         chg_cur_hold;
  wire [RES_W-1:0]         in_volt_hold;

  // charge current with its reserved top bit cleared before it is held
  wire [RES_W-1:0]         chg_cur_masked;

  // packed buses feeding and leaving the holding registers
  wire [RES_W*NUM_RES-1:0] raw_bus;
  wire [RES_W*NUM_RES-1:0] hold_bus;

  // byte views of the held words, as the host sees them
  wire [7:0]               in_cur_hi_byte;
  wire [7:0]               in_cur_lo_byte;
  wire [7:0]               chg_cur_hi_byte;
  wire [7:0]               chg_cur_lo_byte;
  wire [7:0]               in_volt_hi_byte;
  wire [7:0]               in_volt_lo_byte;

  // one-hot address matches
  wire                     sel_in_cur_hi;
  wire                     sel_in_cur_lo;
  wire                     sel_chg_cur_hi;
  wire                     sel_chg_cur_lo;
  wire                     sel_in_volt_hi;
  wire                     sel_in_volt_lo;
  wire                     any_sel;

  // access qualifiers; a read beats a write in the same cycle
  wire                     rd_take;
  wire                     wr_take;

  // combinational next values of the registered read port
  reg  [7:0]               rdata_next;
  reg                      hit_next;

  // charge current is unsigned 15-bit; the reserved top bit is forced low
  // so that a converter glitch on that bit can never reach the host
  assign chg_cur_masked = {1'b0, charge_current_result_in[`ARB_CHGCUR_MAG_W-1:0]};  // [R4] [R5]

  // sign convention (into the pin positive) comes from the converter as is;
  // no re-encoding here keeps the two's complement value intact
  assign raw_bus = {input_voltage_result_in, chg_cur_masked, input_current_result_in};  // [R2] [R3]

  // one holding register per result, all loaded on the same strobe
  genvar gi;
  generate
    for (gi = 0; gi < NUM_RES; gi = gi + 1) begin : g_hold
      arb_result_hold #(
        .WIDTH     (RES_W)
      ) u_hold (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .load_in   (conv_done_in),  // [R9]
        .value_in  (raw_bus[gi*RES_W +: RES_W]),
        .value_out (hold_bus[gi*RES_W +: RES_W])
      );
    end
  endgenerate

  // unpack the held words in the order they were packed
  assign in_cur_hold  = hold_bus[0*RES_W +: RES_W];
  assign chg_cur_hold = hold_bus[1*RES_W +: RES_W];
  assign in_volt_hold = hold_bus[2*RES_W +: RES_W];

  // input current bytes: sign and high weights first, then the low byte
  assign in_cur_hi_byte  = in_cur_hold[`ARB_HI_MSB:`ARB_HI_LSB];  // [R1] [R2]
  assign in_cur_lo_byte  = in_cur_hold[`ARB_LO_MSB:`ARB_LO_LSB];  // [R1]

  // charge current bytes: the upper register carries only seven value bits
  assign chg_cur_hi_byte = {1'b0, chg_cur_hold[`ARB_CHGCUR_HIGH_MSB:`ARB_CHGCUR_HIGH_LSB]};  // [R5]
  assign chg_cur_lo_byte = chg_cur_hold[`ARB_LO_MSB:`ARB_LO_LSB];  // [R4]

  // input voltage bytes: the low byte completes the high one
  assign in_volt_hi_byte = in_volt_hold[`ARB_HI_MSB:`ARB_HI_LSB];  // [R6]
  assign in_volt_lo_byte = in_volt_hold[`ARB_LO_MSB:`ARB_LO_LSB];  // [R8]

  // address matches, each against its own map entry
  assign sel_in_cur_hi  = (reg_addr_in == `ARB_ADDR_INCUR_HIGH);
  assign sel_in_cur_lo  = (reg_addr_in == `ARB_ADDR_INCUR_LOW);
  assign sel_chg_cur_hi = (reg_addr_in == `ARB_ADDR_CHGCUR_HIGH);
  assign sel_chg_cur_lo = (reg_addr_in == `ARB_ADDR_CHGCUR_LOW);
  assign sel_in_volt_hi = (reg_addr_in == `ARB_ADDR_INVOLT_HIGH);
  assign sel_in_volt_lo = (reg_addr_in == `ARB_ADDR_INVOLT_LOW);

  // any mapped address; drives the decode flag
  assign any_sel = sel_in_cur_hi  | sel_in_cur_lo  |
                   sel_chg_cur_hi | sel_chg_cur_lo |
                   sel_in_volt_hi | sel_in_volt_lo;

  // a read and a write together count as a read only
  assign rd_take = reg_rd_in;
  assign wr_take = reg_wr_in & ~reg_rd_in;

  // read decode; writes are ignored since nothing here is writable
  // unmapped addresses read zero so a stray read never leaks a stale byte
  always @* begin
    rdata_next = `ARB_BYTE_ZERO;
    hit_next   = any_sel;
    case (1'b1)
      sel_in_cur_hi: begin
        rdata_next = in_cur_hi_byte;  // [R1] [R2]
      end
      sel_in_cur_lo: begin
        rdata_next = in_cur_lo_byte;  // [R1]
      end
      sel_chg_cur_hi: begin
        rdata_next = chg_cur_hi_byte;  // [R5]
      end
      sel_chg_cur_lo: begin
        rdata_next = chg_cur_lo_byte;  // [R4]
      end
      sel_in_volt_hi: begin
        rdata_next = in_volt_hi_byte;  // [R6]
      end
      sel_in_volt_lo: begin
        rdata_next = in_volt_lo_byte;  // [R8]
      end
      default: begin
        rdata_next = `ARB_BYTE_ZERO;
      end
    endcase
  end

  // read data registered one cycle after the read strobe; it then stands
  // until the next read, so a slow serial front end may fetch it late
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= `ARB_BYTE_ZERO;  // [R7]
    end else if (rd_take) begin
      reg_rdata_out <= rdata_next;
    end
  end

  // decode flag follows every read or write; write data itself is dropped
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_hit_out <= 1'b0;
    end else if (rd_take | wr_take) begin
      reg_hit_out <= hit_next;  // [R7] write changes no data
    end
  end

  // write data has nowhere to go; kept as a port for the shared register port
  wire unused_wdata = ^reg_wdata_in;
endmodule // arb_result_bank
`default_nettype wire

/* File: include/arb_map.vh */
// register map, field layout and reset values of the converter result readout bank
// Functional notes
// R1: The input-bus current result is a 16-bit value with its upper byte at 17h and its lower byte at 18h.
// R2: The input-bus current result is two's complement with bit 15 as sign and bits 14..0 weighing 16384 mA down to 1 mA.
// R3: Current flowing into the input supply pin reads positive and current flowing out reads negative.
// R4: The charge current result has its upper seven bits at 19h and its lower byte at 1Ah, bit 14 weighing 16384 mA and bit 0 weighing 1 mA.
// R5: The top bit of the charge current upper-byte register is reserved and always reads zero.
// R6: The upper byte of the input-bus voltage result sits at 1Bh with a sign in bit 15 and bits 14..8 weighing 16384 mV to 256 mV.
// R7: Every result register resets to zero and software writes to them have no effect.
// R8: The lower byte of the input-bus voltage result sits at 1Ch with bit 0 weighing 1 mV.
// R9: High and low bytes of a result are updated together when a conversion completes.
`ifndef ARB_MAP_VH
`define ARB_MAP_VH
`define ARB_ADDR_W            8
`define ARB_ADDR_INCUR_HIGH   8'h17
`define ARB_ADDR_INCUR_LOW    8'h18
`define ARB_ADDR_CHGCUR_HIGH  8'h19
`define ARB_ADDR_CHGCUR_LOW   8'h1a
`define ARB_ADDR_INVOLT_HIGH  8'h1b
`define ARB_ADDR_INVOLT_LOW   8'h1c
`define ARB_RESULT_RESET      16'h0000
`define ARB_BYTE_ZERO         8'h00
`define ARB_CHGCUR_MAG_W      15
`define ARB_CHGCUR_HIGH_MSB   14
`define ARB_CHGCUR_HIGH_LSB   8
`define ARB_HI_MSB            15
`define ARB_HI_LSB            8
`define ARB_LO_MSB            7
`define ARB_LO_LSB            0
`define ARB_NUM_RES           3
`endif

/* File: src/arb_result_hold.v */
// one result holding register: both bytes load together on a conversion strobe
`timescale 1ns/10ps
`default_nettype none
`include "arb_map.vh"
module arb_result_hold #(
  parameter WIDTH = 16
) (
  // clock and reset
  input  wire             mclk_in,
  input  wire             rst_in,
  // conversion result
  input  wire             load_in,
  input  wire [WIDTH-1:0] value_in,
  // held value
  output reg  [WIDTH-1:0] value_out
);
  // one load moves the whole word, so a host never sees half a new value
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      value_out <= `ARB_RESULT_RESET;  // [R7]
    end else if (load_in) begin
      value_out <= value_in;  // [R9]
    end
  end
endmodule // arb_result_hold
`default_nettype wire

/* File: verif/arb_result_bank_chk.sv */
// checker of the result bank read port
`timescale 1ns/10ps
`default_nettype none
module arb_result_bank_chk(input wire logic mclk_in,rst_in,conv_done_in,reg_rd_in,reg_wr_in,
  input wire logic [15:0] input_current_result_in,charge_current_result_in,input_voltage_result_in,
  input wire logic [7:0] reg_addr_in,reg_wdata_in,reg_rdata_out,input wire logic reg_hit_out);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic [15:0] i,c,v; // shadow words, both bytes move as one
  wire logic r=reg_rd_in;
  wire logic [7:0] a=reg_addr_in,d=reg_rdata_out;
  wire logic m=a>=8'h17&&a<=8'h1c;
  // shadow loads on the strobe only
  always_ff @(posedge mclk_in or posedge rst_in)
    if (rst_in) {i,c,v} <= '0;
    else if (conv_done_in) {i,c,v} <= {input_current_result_in,charge_current_result_in,
      input_voltage_result_in};
  chk_ib_hi: assert property(r&&a==8'h17|=>d==$past(i[15:8]))else $error("bad 17h");
  chk_ib_lo: assert property(r&&a==8'h18|=>d==$past(i[7:0]))else $error("bad 18h");
  chk_ic_hi: assert property(r&&a==8'h19|=>d=={1'b0,$past(c[14:8])})else $error("19h");
  chk_ic_lo: assert property(r&&a==8'h1a|=>d==$past(c[7:0]))else $error("bad 1ah");
  chk_vb_hi: assert property(r&&a==8'h1b|=>d==$past(v[15:8]))else $error("bad 1bh");
  chk_vb_lo: assert property(r&&a==8'h1c|=>d==$past(v[7:0]))else $error("bad 1ch");
  chk_hit_map: assert property(r||reg_wr_in|=>reg_hit_out==$past(m))else $error("hit");
  chk_no_map: assert property(r&&!m|=>d==8'h00&&!reg_hit_out)else $error("unmapped");
  cover property(conv_done_in);
  cover property(reg_wr_in&&m);
  cover property(r&&!m);
endmodule // arb_result_bank_chk
`default_nettype wire

/* File: verif/arb_host_model.sv */
// host model issuing single register accesses
`timescale 1ns/10ps
`default_nettype none
module arb_host_model(input wire logic mclk_in,input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,wdata_out,output logic rd_out,wr_out);
  initial {addr_out,wdata_out,rd_out,wr_out} = 18'h0_0000;
  // strobe for one edge, answer taken just after the next
  task automatic access(input logic w,input logic [7:0] ad,wd,output logic [7:0] q);
    @(posedge mclk_in);
    {addr_out,wdata_out,rd_out,wr_out} <= {ad,wd,!w,w};
    @(posedge mclk_in);
    {wdata_out,rd_out,wr_out} <= {~wd,2'b00}; // released data never looks valid
    #1 q = rdata_in;
  endtask
endmodule // arb_host_model
`default_nettype wire

/* File: verif/tb_arb_result_bank.sv */
// testbench of the converter result register bank
`timescale 1ns/10ps
`default_nettype none
module tb_arb_result_bank;
  logic mclk_in=1'b0,rst_in=1'b1,cv=1'b0,rd,wr,hit;
  logic [15:0] ib=16'h0000,ic=16'h0000,vb=16'h0000;
  logic [7:0] a,wd,d,q;
  int n_fail=0,check_count=0;
  always #5 mclk_in = ~mclk_in;
  arb_host_model arb_host_model_inst(.mclk_in(mclk_in),.rdata_in(d),.addr_out(a),
    .wdata_out(wd),.rd_out(rd),.wr_out(wr));
  arb_result_bank arb_result_bank_inst(.mclk_in(mclk_in),.rst_in(rst_in),.conv_done_in(cv),
    .input_current_result_in(ib),.charge_current_result_in(ic),.input_voltage_result_in(vb),
    .reg_addr_in(a),.reg_rd_in(rd),.reg_wr_in(wr),.reg_wdata_in(wd),.reg_rdata_out(d),
    .reg_hit_out(hit));
  task automatic cmp(input string n,input logic [7:0] e,s);
    check_count++;
    if (s!==e) begin n_fail++; $display("[FAIL] %s exp %h got %h",n,e,s); end
  endtask
  // read one address, check data and decode flag
  task automatic rc(input logic [7:0] ad,e);
    arb_host_model_inst.access(1'b0,ad,8'h00,q);
    cmp("rdata",e,q);
    cmp("hit",{7'h00,ad>=8'h17&&ad<=8'h1c},{7'h00,hit});
  endtask
  // inputs flip after the strobe, so only the held words may show
  task automatic t_value;
    @(posedge mclk_in);
    {ib,ic,vb,cv} <= {16'h8001,16'hffff,16'h7f00,1'b1};
    @(posedge mclk_in);
    {ib,ic,vb,cv} <= {16'h7ffe,16'h0000,16'h80ff,1'b0};
    rc(8'h17,8'h80);
    rc(8'h18,8'h01);
    rc(8'h19,8'h7f);
    rc(8'h1a,8'hff);
    rc(8'h1b,8'h7f);
    rc(8'h1c,8'h00);
    arb_host_model_inst.access(1'b1,8'h17,8'h55,q);
    rc(8'h17,8'h80);
    rc(8'h16,8'h00);
    rc(8'h1d,8'h00);
    rc(8'h19,8'h7f);
    $display("value test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d",check_count,n_fail);
    if (n_fail==0&&check_count>0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    for (int k=8'h17; k<=8'h1c; k++) rc(k[7:0],8'h00);
    $display("reset test done");
    t_value();
    end_of_test();
  end
  initial begin
    #100000 n_fail++;
    end_of_test();
  end
endmodule // tb_arb_result_bank
bind arb_result_bank arb_result_bank_chk arb_result_bank_chk_inst(.*);
`default_nettype wire
